//--- hw/wdg_pkg.sv
// Purpose: Constants for the windowed host watchdog configuration and timing block
// Assumes: Byte-wide register port, writes at even and reads at odd addresses
// Notes:   All offsets, field positions, reset values and widths live here
//
// Functional notes
// - Open window starts timing period times (close count+1) times 8 after the interval start; a stretched first interval opens later.
// - Timing clock is derived by a divider from a 5-bit field, bits 4:0.
// - Enable bit 7 turns watchdog on; resets to 0, so disabled.
// - Style bit 3: 0 challenge/response, 1 standard windowed; resets to 0.
// - Safe monitoring after 1,2,4..128 consecutive violations set by 3-bit code.
package wdg_pkg;

	// ****************************************************************
	// Register addresses (write / read)
	// ****************************************************************
	localparam logic [7:0] ADDR_WINDOW_COUNT_WR   = 8'h84;
	localparam logic [7:0] ADDR_WINDOW_COUNT_RD   = 8'h85;
	localparam logic [7:0] ADDR_EXT_DIV_WR        = 8'h86;
	localparam logic [7:0] ADDR_EXT_DIV_RD        = 8'h87;
	localparam logic [7:0] ADDR_ENABLE_MODE_WR    = 8'h88;
	localparam logic [7:0] ADDR_ENABLE_MODE_RD    = 8'h89;
	localparam logic [7:0] ADDR_STATUS_RD         = 8'h8B;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] WINDOW_COUNT_RESET     = 8'h00;
	localparam logic [7:0] EXT_DIV_RESET          = 8'h00;
	localparam logic [7:0] ENABLE_MODE_RESET      = 8'h00;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int OPEN_COUNT_MSB     = 7;
	localparam int OPEN_COUNT_LSB     = 4;
	localparam int CLOSE_COUNT_MSB    = 3;
	localparam int CLOSE_COUNT_LSB    = 0;
	localparam int FIRST_EXT_MSB      = 7;
	localparam int FIRST_EXT_LSB      = 5;
	localparam int DIVIDER_MSB        = 4;
	localparam int DIVIDER_LSB        = 0;
	localparam int WATCHDOG_ON_BIT    = 7;
	localparam int STYLE_BIT          = 3;
	localparam int DEBOUNCE_MSB       = 2;
	localparam int DEBOUNCE_LSB       = 0;
	localparam int ENABLE_MODE_MASK_W = 8;
	localparam logic [7:0] ENABLE_MODE_MASK = 8'h8F;

	// Status register bits
	localparam int STAT_OPEN_BIT      = 0;
	localparam int STAT_FIRST_BIT     = 1;
	localparam int STAT_SAFE_BIT      = 2;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLOSE_MULT_SHIFT   = 3;
	localparam int INTERVAL_W         = 11;
	localparam int VIOL_CNT_W         = 9;

endpackage : wdg_pkg

//--- hw/windowed_watchdog_config.sv
// Purpose: Windowed host watchdog with its configuration registers and violation debounce
// Assumes: Register port and service pulses come from logic on clk
// Notes:   Timing is counted in ticks of the divided timing clock
`timescale 1ns/1ns
module windowed_watchdog_config (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	// Servicing events
	input  wire logic        refresh_pulse,
	input  wire logic        challenge_pass,
	// Status
	output logic             window_open,
	output logic             violation,
	output logic             safe_monitor,
	output logic             windowed_style
);

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	logic [7:0] window_count_cfg_q;
	logic [7:0] watchdog_extension_divider_cfg_q;
	logic [7:0] watchdog_enable_mode_cfg_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			window_count_cfg_q               <= wdg_pkg::WINDOW_COUNT_RESET;
			watchdog_extension_divider_cfg_q <= wdg_pkg::EXT_DIV_RESET;
			watchdog_enable_mode_cfg_q       <= wdg_pkg::ENABLE_MODE_RESET;
		end else if (reg_wr) begin
			// Writes are taken even while enabled; the host is trusted not to retime a live window
			case (reg_addr)
				wdg_pkg::ADDR_WINDOW_COUNT_WR: window_count_cfg_q               <= reg_wdata;
				wdg_pkg::ADDR_EXT_DIV_WR:      watchdog_extension_divider_cfg_q <= reg_wdata;
				wdg_pkg::ADDR_ENABLE_MODE_WR:  watchdog_enable_mode_cfg_q       <= reg_wdata & wdg_pkg::ENABLE_MODE_MASK;
				default: ;
			endcase
		end
	end

	logic [3:0] open_window_count;
	logic [3:0] close_window_count;
	logic [2:0] first_update_extension;
	logic [4:0] timing_clock_divider;
	logic       watchdog_on;
	logic [2:0] violation_debounce;

	assign open_window_count      = window_count_cfg_q[wdg_pkg::OPEN_COUNT_MSB:wdg_pkg::OPEN_COUNT_LSB];
	assign close_window_count     = window_count_cfg_q[wdg_pkg::CLOSE_COUNT_MSB:wdg_pkg::CLOSE_COUNT_LSB];
	assign first_update_extension = watchdog_extension_divider_cfg_q[wdg_pkg::FIRST_EXT_MSB:wdg_pkg::FIRST_EXT_LSB];
	assign timing_clock_divider   = watchdog_extension_divider_cfg_q[wdg_pkg::DIVIDER_MSB:wdg_pkg::DIVIDER_LSB];
	assign watchdog_on            = watchdog_enable_mode_cfg_q[wdg_pkg::WATCHDOG_ON_BIT];
	assign windowed_style         = watchdog_enable_mode_cfg_q[wdg_pkg::STYLE_BIT];
	assign violation_debounce     = watchdog_enable_mode_cfg_q[wdg_pkg::DEBOUNCE_MSB:wdg_pkg::DEBOUNCE_LSB];

	// ****************************************************************
	// Timing clock divider
	// ****************************************************************
	logic [4:0] div_cnt_q;
	logic       tick;

	// Held at zero while off, so the first tick comes div+1 cycles after enable
	assign tick = watchdog_on && (div_cnt_q == timing_clock_divider);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			div_cnt_q <= 5'h00;
		end else if (!watchdog_on || tick) begin
			div_cnt_q <= 5'h00;
		end else begin
			div_cnt_q <= 5'(div_cnt_q + 5'h01);
		end
	end

	// ****************************************************************
	// Window arithmetic
	// ****************************************************************
	logic [7:0]                     closed_len;
	logic [4:0]                     open_len;
	logic [7:0]                     normal_len;
	logic [wdg_pkg::INTERVAL_W-1:0] interval_len;
	logic [wdg_pkg::INTERVAL_W-1:0] closed_end;
	logic                           first_q;
	logic [3:0]                     ext_mult;
	logic [wdg_pkg::INTERVAL_W-1:0] first_len;

	assign closed_len   = 8'({4'h0, close_window_count} + 8'h01) << wdg_pkg::CLOSE_MULT_SHIFT;
	assign open_len     = 5'({1'b0, open_window_count} + 5'h01);
	assign normal_len   = 8'(closed_len + {3'h0, open_len});
	// Both factors are widened first so the stretched length cannot wrap (worst case 144 times 8)
	assign ext_mult     = 4'({1'b0, first_update_extension} + 4'h1);
	assign first_len    = wdg_pkg::INTERVAL_W'({3'h0, normal_len} * {7'h00, ext_mult});
	// First interval is stretched as a whole; the open part keeps its normal length at the end
	assign interval_len = first_q ? first_len : {3'h0, normal_len};
	assign closed_end   = wdg_pkg::INTERVAL_W'(interval_len - {6'h00, open_len});

	// ****************************************************************
	// Interval timing
	// ****************************************************************
	logic [wdg_pkg::INTERVAL_W-1:0] elapsed_q;
	logic                           watchdog_on_q;
	logic                           service;
	logic                           expire;
	logic                           early;
	logic                           last_tick;

	assign service     = windowed_style ? refresh_pulse : challenge_pass;
	assign window_open = watchdog_on && (elapsed_q >= closed_end);
	assign early       = watchdog_on && service && !window_open;
	// Compared with the live length, so the first interval ends at its stretched end
	assign last_tick   = (elapsed_q == wdg_pkg::INTERVAL_W'(interval_len - 11'h001));
	assign expire      = tick && !service && last_tick;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			watchdog_on_q <= 1'b0;
		end else begin
			watchdog_on_q <= watchdog_on;
		end
	end

	// Rises one cycle after enable; that cycle counts at normal length, too short to end an interval
	always_ff @(posedge clk) begin
		if (!rstn) begin
			first_q <= 1'b0;
		end else if (watchdog_on && !watchdog_on_q) begin
			first_q <= 1'b1;
		end else if ((watchdog_on && service) || expire || !watchdog_on) begin
			first_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			elapsed_q <= '0;
		end else if (!watchdog_on || service || expire) begin
			elapsed_q <= '0;
		end else if (tick) begin
			elapsed_q <= wdg_pkg::INTERVAL_W'(elapsed_q + 11'h001);
		end
	end

	// ****************************************************************
	// Violation debounce
	// ****************************************************************
	logic [wdg_pkg::VIOL_CNT_W-1:0] viol_cnt_q;
	logic [wdg_pkg::VIOL_CNT_W-1:0] viol_cnt_inc;
	logic [wdg_pkg::VIOL_CNT_W-1:0] viol_limit;
	logic                           is_viol;

	assign is_viol      = early || expire;
	assign viol_cnt_inc = wdg_pkg::VIOL_CNT_W'(viol_cnt_q + 9'h001);
	assign viol_limit   = wdg_pkg::VIOL_CNT_W'(9'h001 << violation_debounce);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			viol_cnt_q <= '0;
		end else if (!watchdog_on || (service && window_open)) begin
			viol_cnt_q <= '0;
		end else if (is_viol && viol_cnt_q < viol_limit) begin
			// Saturates at the limit, so a long outage cannot wrap the count
			viol_cnt_q <= viol_cnt_inc;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			violation    <= 1'b0;
			safe_monitor <= 1'b0;
		end else begin
			violation <= is_viol;
			// Safe state holds until software disables the watchdog
			if (!watchdog_on) begin
				safe_monitor <= 1'b0;
			end else if (is_viol && viol_cnt_inc >= viol_limit) begin
				safe_monitor <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Status byte
	// ****************************************************************
	logic [7:0] status_byte;

	// Unused bits read as zero
	always_comb begin
		status_byte                          = 8'h00;
		status_byte[wdg_pkg::STAT_OPEN_BIT]  = window_open;
		status_byte[wdg_pkg::STAT_FIRST_BIT] = first_q;
		status_byte[wdg_pkg::STAT_SAFE_BIT]  = safe_monitor;
	end

	// ****************************************************************
	// Register read-back
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					wdg_pkg::ADDR_WINDOW_COUNT_RD: reg_rdata <= window_count_cfg_q;
					wdg_pkg::ADDR_EXT_DIV_RD:      reg_rdata <= watchdog_extension_divider_cfg_q;
					wdg_pkg::ADDR_ENABLE_MODE_RD:  reg_rdata <= watchdog_enable_mode_cfg_q;
					wdg_pkg::ADDR_STATUS_RD:       reg_rdata <= status_byte;
					default:                       reg_rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule : windowed_watchdog_config

//--- verification/wdg_host_model.sv
// Purpose: Host side that services the watchdog on request
// Assumes: Service lines are one-cycle pulses launched after a clock edge
// Notes:   Waits for the open window unless asked to service early
`timescale 1ns/1ns
module wdg_host_model (
	// Control from the bench
	input  wire logic clk,
	input  wire logic req,
	input  wire logic early,
	// Watchdog side
	input  wire logic window_open,
	input  wire logic windowed_style,
	output logic      refresh_pulse,
	output logic      challenge_pass,
	output logic      done
);
	initial begin
		refresh_pulse = 1'b0;
		challenge_pass = 1'b0;
		done = 1'b0;
	end
	always @(posedge clk) begin
		refresh_pulse <= 1'b0;
		challenge_pass <= 1'b0;
		if (req && !done && (early || window_open)) begin
			refresh_pulse <= windowed_style;
			challenge_pass <= !windowed_style;
			done <= 1'b1;
		end else if (!req) begin
			done <= 1'b0;
		end
	end
endmodule : wdg_host_model

//--- verification/windowed_watchdog_config_monitor.sv
// Purpose: Port-level checks of the windowed watchdog
// Assumes: Sees only the top module ports
// Notes:   on_q mirrors the enable bit as written by the host
`timescale 1ns/1ns
module windowed_watchdog_config_monitor (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       refresh_pulse,
	input wire logic       challenge_pass,
	input wire logic       window_open,
	input wire logic       violation,
	input wire logic       safe_monitor,
	input wire logic       windowed_style
);
	logic on_q;
	logic svc;
	assign svc = windowed_style ? refresh_pulse : challenge_pass;
	always_ff @(posedge clk) begin
		if (!rstn) on_q <= 1'b0;
		else if (reg_wr && reg_addr == wdg_pkg::ADDR_ENABLE_MODE_WR) on_q <= reg_wdata[7];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
	idle_read_a: assert property (!reg_rd |=> !reg_rvalid) else $error("answer without read");
	style_follow_a: assert property (reg_wr && reg_addr == 8'h88 |=> windowed_style == $past(reg_wdata[3]))
		else $error("style bit not followed");
	off_closed_a: assert property (!on_q |-> !window_open) else $error("window open while off");
	off_safe_a: assert property (!on_q |=> !safe_monitor) else $error("safe mode while off");
	early_service_a: assert property (on_q && svc && !window_open |-> ##[1:2] violation)
		else $error("early service not flagged");
	closed_span_a: assert property (on_q && svc && window_open |=> !window_open [*8])
		else $error("closed window too short");
	good_service_a: assert property (on_q && svc && window_open |-> ##1 !violation ##1 !violation)
		else $error("valid service flagged");
	safe_rise_a: assert property ($rose(safe_monitor) |-> violation) else $error("safe mode without violation");
	cover property (on_q && svc && window_open);
	cover property (on_q && svc && !window_open);
	cover property (safe_monitor);
endmodule : windowed_watchdog_config_monitor

//--- verification/windowed_watchdog_config_tb_top.sv
// Purpose: Register and servicing tests of the windowed watchdog
// Assumes: Bench drives on the falling edge
// Notes:   Divider kept at zero where exact cycle counts are compared, except the divided span check at divider 1
`timescale 1ns/1ns
module windowed_watchdog_config_tb_top;
	logic       clk, rstn, reg_wr, reg_rd, req, early, done;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       reg_rvalid, refresh_pulse, challenge_pass, window_open, violation, safe_monitor, windowed_style;
	int         failures = 0, cmp_count = 0, vcnt = 0, n, v;
	windowed_watchdog_config dut_u (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .refresh_pulse(refresh_pulse),
		.challenge_pass(challenge_pass), .window_open(window_open), .violation(violation),
		.safe_monitor(safe_monitor), .windowed_style(windowed_style));
	wdg_host_model host_u (.clk(clk), .req(req), .early(early), .window_open(window_open),
		.windowed_style(windowed_style), .refresh_pulse(refresh_pulse), .challenge_pass(challenge_pass), .done(done));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (violation === 1'b1) vcnt <= vcnt + 1;
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk); reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
		@(negedge clk); reg_wr = 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk); reg_rd = 1'b1; reg_addr = a;
		@(negedge clk); reg_rd = 1'b0;
		chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
		chk("rdata", reg_rdata, exp);
	endtask : rd
	// A wait loop that runs out counts as a mismatch
	task limit_chk(input string what, input int lim);
		if (n >= lim) begin
			failures++;
			$display("Error %s limit expected below %0d seen %0d", what, lim, n);
		end
	endtask : limit_chk
	// Counts cycles until the open window starts
	task measure;
		n = 0;
		while (window_open !== 1'b1 && n < 400) begin @(negedge clk); n++; end
		limit_chk("measure", 400);
	endtask : measure
	task service(input logic e);
		early = e; req = 1'b1; n = 0;
		while (done !== 1'b1 && n < 400) begin @(negedge clk); n++; end
		limit_chk("service", 400);
		req = 1'b0; early = 1'b0;
		@(negedge clk);
	endtask : service
	task wait_viol(input int target);
		n = 0;
		while (vcnt < target && n < 3000) begin @(negedge clk); n++; end
		limit_chk("violations", 3000);
		@(negedge clk);
	endtask : wait_viol
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	// Hang guard well beyond the few thousand cycles the tests need
	initial begin
		#300000;
		failures++;
		complete_run();
	end
	initial begin
		rstn = 0; reg_wr = 0; reg_rd = 0; reg_addr = 8'h00; reg_wdata = 8'h00; req = 0; early = 0;
		repeat (12) @(negedge clk);
		rstn = 1;
		rd(8'h85, 8'h00);
		rd(8'h87, 8'h00);
		rd(8'h89, 8'h00);
		rd(8'h80, 8'h00);
		wr(8'h84, 8'hA5);
		rd(8'h85, 8'hA5);
		wr(8'h86, 8'hFF);
		rd(8'h87, 8'hFF);
		wr(8'h88, 8'hFF);
		rd(8'h89, 8'h8F);
		chk("style", {7'h00, windowed_style}, 8'h01);
		wr(8'h88, 8'h00);
		wr(8'h86, 8'h00);
		$display("test registers done");
		for (int c = 0; c < 3; c++) begin
			wr(8'h84, 8'h30 | 8'(c));
			wr(8'h88, 8'h8B);
			measure();
			chk("closed after enable", 8'(n), 8'((c + 1) * 8));
			v = vcnt;
			service(1'b0);
			measure();
			chk("closed after refresh", 8'(n), 8'((c + 1) * 8));
			chk("no violation", 8'(vcnt - v), 8'h00);
			wr(8'h88, 8'h00);
		end
		wr(8'h84, 8'h30);
		wr(8'h86, 8'h20);
		wr(8'h88, 8'h8B);
		measure();
		chk("first interval", 8'(n), 8'h14);
		service(1'b0);
		measure();
		chk("later interval", 8'(n), 8'h08);
		wr(8'h88, 8'h00);
		wr(8'h86, 8'h01);
		wr(8'h88, 8'h8B);
		measure();
		chk("divided span", 8'(n), 8'h10);
		wr(8'h88, 8'h00);
		wr(8'h86, 8'h00);
		wr(8'h88, 8'h80);
		chk("style", {7'h00, windowed_style}, 8'h00);
		v = vcnt;
		service(1'b1);
		repeat (3) @(negedge clk);
		chk("early violation", 8'(vcnt - v), 8'h01);
		chk("safe", {7'h00, safe_monitor}, 8'h01);
		wr(8'h88, 8'h00);
		// Safe state drops one cycle after the enable bit clears
		@(negedge clk);
		chk("safe off", {7'h00, safe_monitor}, 8'h00);
		wr(8'h88, 8'h80);
		measure();
		chk("challenge closed", 8'(n), 8'h08);
		v = vcnt;
		service(1'b0);
		measure();
		chk("challenge refresh", 8'(n), 8'h08);
		chk("challenge no violation", 8'(vcnt - v), 8'h00);
		wr(8'h88, 8'h00);
		$display("test timing done");
		for (int d = 0; d < 8; d++) begin
			wr(8'h88, 8'h88 | 8'(d));
			v = vcnt;
			wait_viol(v + (1 << d) - 1);
			chk("safe early", {7'h00, safe_monitor}, 8'h00);
			wait_viol(v + (1 << d));
			chk("safe reached", {7'h00, safe_monitor}, 8'h01);
			rd(8'h8B, 8'h04);
			wr(8'h88, 8'h00);
		end
		$display("test debounce done");
		// Reset in mid-run while the watchdog is live
		wr(8'h88, 8'h88);
		repeat (4) @(negedge clk);
		rstn = 1'b0;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		chk("open after reset", {7'h00, window_open}, 8'h00);
		rd(8'h89, 8'h00);
		rd(8'h85, 8'h00);
		$display("test reset done");
		complete_run();
	end
endmodule : windowed_watchdog_config_tb_top
bind windowed_watchdog_config windowed_watchdog_config_monitor mon_u (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.refresh_pulse(refresh_pulse), .challenge_pass(challenge_pass), .window_open(window_open),
	.violation(violation), .safe_monitor(safe_monitor), .windowed_style(windowed_style));
